//--- core/eas_slave.sv
`timescale 1ns/10ps
`default_nettype none
module eas_slave (
	input  wire logic                clk_sys_in,
	input  wire logic                rst_b_in,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe_out,
	input  wire logic                chip_enable_strap_2_in,
	input  wire logic                chip_enable_strap_1_in,
	input  wire logic                chip_enable_strap_0_in,
	input  wire logic                write_protect_input_in,
	input  wire logic                write_busy_in,
	output eas_pkg::eas_xfer_t       xfer_out,
	output logic                     addr_valid_out,
	output logic [7:0]               data_out,
	output logic                     data_valid_out,
	output logic                     write_start_out
);
	import eas_pkg::*;

	// --------------------------------------------------
	// pin synchronisation and line events
	// --------------------------------------------------
	eas_pins_t  pins_raw;
	eas_pins_t  pins_s;
	logic       scl_d_reg;
	logic       sda_d_reg;

	assign pins_raw = '{scl: scl_in, sda: sda_in, ce2: chip_enable_strap_2_in,
		ce1: chip_enable_strap_1_in, ce0: chip_enable_strap_0_in, wp: write_protect_input_in};

	eas_sync #(.WIDTH($bits(eas_pins_t))) u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.async_in   (pins_raw),
		.sync_out   (pins_s)
	);

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_d_reg <= 1'b0;
			sda_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= pins_s.scl;
			sda_d_reg <= pins_s.sda;
		end
	end

	wire scl_rise  = pins_s.scl && !scl_d_reg;
	wire scl_fall  = !pins_s.scl && scl_d_reg;
	wire scl_high  = pins_s.scl && scl_d_reg;
	wire start_det = scl_high && sda_d_reg && !pins_s.sda;
	wire stop_det  = scl_high && !sda_d_reg && pins_s.sda;
	wire start_ok  = start_det && !write_busy_in;

	// --------------------------------------------------
	// byte shifter
	// --------------------------------------------------
	eas_state_t state_reg;
	eas_state_t state_next;
	logic [7:0] shift_byte;
	logic [3:0] bit_cnt;
	logic       byte_done;
	logic       ack_clk;

	wire receiving = (state_reg == ST_SELECT) || (state_reg == ST_ADDR_HI) ||
		(state_reg == ST_ADDR_LO) || (state_reg == ST_DATA);
	wire sample    = scl_rise && receiving;

	eas_shift u_shift (
		.clk_sys_in    (clk_sys_in),
		.rst_b_in      (rst_b_in),
		.clear_in      (start_ok),
		.sample_in     (sample),
		.bit_in        (pins_s.sda),
		.byte_out      (shift_byte),
		.count_out     (bit_cnt),
		.byte_done_out (byte_done),
		.ack_clk_out   (ack_clk)
	);

	// --------------------------------------------------
	// select and address decode
	// --------------------------------------------------
	wire [SEL_TYPE_W-1:0] sel_type  = shift_byte[SEL_TYPE_LSB +: SEL_TYPE_W];
	wire [SEL_CE_W-1:0]   sel_ce    = shift_byte[SEL_CE_LSB +: SEL_CE_W];
	wire [SEL_CE_W-1:0]   strap_ce  = {pins_s.ce2, pins_s.ce1, pins_s.ce0};
	wire                  type_main = (sel_type == TYPE_MAIN);
	wire                  type_id   = (sel_type == TYPE_IDPAGE);
	wire                  ce_match  = (sel_ce == strap_ce);
	wire                  sel_match = (type_main || type_id) && ce_match;
	wire                  sel_rd    = shift_byte[SEL_RW_BIT];
	wire                  wp_high   = pins_s.wp;

	logic [7:0] addr_hi_reg;
	wire  [BYTE_ADDR_W-1:0] main_addr = {addr_hi_reg[MAIN_HI_W-1:0], shift_byte};
	wire  [BYTE_ADDR_W-1:0] id_addr   = {{(BYTE_ADDR_W-ID_ADDR_W){1'b0}}, shift_byte[ID_ADDR_W-1:0]};

	// --------------------------------------------------
	// acknowledge decision
	// --------------------------------------------------
	logic ack_want;
	always_comb begin
		ack_want = 1'b0;
		if (byte_done) begin
			case (state_reg)
				ST_SELECT: begin
					ack_want = sel_match;
				end
				ST_ADDR_HI, ST_ADDR_LO: begin
					ack_want = 1'b1;
				end
				ST_DATA: begin
					ack_want = !wp_high;
				end
				default: begin
					ack_want = 1'b0;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// state machine
	// --------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (write_busy_in) begin
			state_next = ST_IDLE;
		end else if (start_det) begin
			state_next = ST_SELECT;
		end else if (stop_det) begin
			state_next = ST_IDLE;
		end else if (byte_done) begin
			case (state_reg)
				ST_SELECT: begin
					if (!sel_match) begin
						state_next = ST_STANDBY;
					end else if (sel_rd) begin
						state_next = ST_READ;
					end else begin
						state_next = ST_ADDR_HI;
					end
				end
				ST_ADDR_HI: begin
					state_next = ST_ADDR_LO;
				end
				ST_ADDR_LO: begin
					state_next = ST_DATA;
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// registers
	// --------------------------------------------------
	logic      ack_pend_reg;
	logic      sda_oe_reg;
	logic      data_seen_reg;
	eas_xfer_t xfer_reg;
	logic      addr_valid_reg;
	logic [7:0] data_reg;
	logic      data_valid_reg;
	logic      write_start_reg;

	wire line_reset   = write_busy_in || start_det || stop_det;
	wire write_commit = stop_det && (state_reg == ST_DATA) && data_seen_reg &&
		(bit_cnt == BIT_STOP) && !wp_high && !write_busy_in;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// open-drain drive: low through the ninth clock only
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_pend_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (line_reset) begin
			ack_pend_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (byte_done) begin
			ack_pend_reg <= ack_want;
		end else if (scl_fall && ack_pend_reg) begin
			ack_pend_reg <= 1'b0;
			sda_oe_reg   <= 1'b1;
		end else if (scl_fall) begin
			sda_oe_reg   <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_hi_reg <= 8'h00;
			xfer_reg    <= '0;
		end else if (byte_done && (state_reg == ST_SELECT) && sel_match) begin
			xfer_reg.is_id <= type_id;
			xfer_reg.rd    <= sel_rd;
		end else if (byte_done && (state_reg == ST_ADDR_HI)) begin
			addr_hi_reg <= shift_byte;
		end else if (byte_done && (state_reg == ST_ADDR_LO)) begin
			xfer_reg.byte_addr <= xfer_reg.is_id ? id_addr : main_addr;
			xfer_reg.lock_cmd  <= xfer_reg.is_id && addr_hi_reg[ID_LOCK_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_valid_reg  <= 1'b0;
			data_reg        <= 8'h00;
			data_valid_reg  <= 1'b0;
			data_seen_reg   <= 1'b0;
			write_start_reg <= 1'b0;
		end else begin
			addr_valid_reg  <= byte_done && (state_reg == ST_ADDR_LO) && !line_reset;
			data_valid_reg  <= byte_done && (state_reg == ST_DATA) && !wp_high && !line_reset;
			write_start_reg <= write_commit;
			if (byte_done && (state_reg == ST_DATA)) begin
				data_reg <= shift_byte;
			end
			if (line_reset) begin
				data_seen_reg <= 1'b0;
			end else if (byte_done && (state_reg == ST_DATA) && !wp_high) begin
				data_seen_reg <= 1'b1;
			end
		end
	end

	// --------------------------------------------------
	// outputs
	// --------------------------------------------------
	assign sda_out         = 1'b0;
	assign sda_oe_out      = sda_oe_reg;
	assign xfer_out        = xfer_reg;
	assign addr_valid_out  = addr_valid_reg;
	assign data_out        = data_reg;
	assign data_valid_out  = data_valid_reg;
	assign write_start_out = write_start_reg;

	// --------------------------------------------------
	// assertions
	// --------------------------------------------------
	property p_only_low_drive;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		sda_oe_out |-> (sda_out == 1'b0) && (state_reg != ST_IDLE) && (state_reg != ST_READ || xfer_reg.rd);
	endproperty
	a_only_low_drive: assert property (p_only_low_drive) else $error("sda driven outside a transfer");

	property p_start_to_select;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(start_det && !write_busy_in) |=> (state_reg == ST_SELECT) && (bit_cnt == BIT_FIRST);
	endproperty
	a_start_to_select: assert property (p_start_to_select) else $error("start not taken");

	property p_busy_ignores;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		write_busy_in |=> (state_reg == ST_IDLE) && !sda_oe_out;
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) else $error("bus answered during write cycle");

	property p_stop_idle;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		stop_det && !start_det |=> (state_reg == ST_IDLE) && !sda_oe_out && !ack_pend_reg;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

	property p_write_trigger;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		write_start_out |-> $past(stop_det) && ($past(state_reg) == ST_DATA) && $past(data_seen_reg);
	endproperty
	a_write_trigger: assert property (p_write_trigger) else $error("write cycle started without data stop");

	property p_ack_slot;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$rose(sda_oe_out) |-> $past(scl_fall) && (bit_cnt == BIT_ACK) ##1 sda_oe_out [*2];
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("ack drive outside ninth bit");

	property p_ack_held;
		@(posedge clk_sys_in) disable iff (!rst_b_in) ack_clk && (state_reg inside {ST_ADDR_HI, ST_ADDR_LO}) |-> sda_oe_out;
	endproperty
	a_ack_held: assert property (p_ack_held) else $error("ack released before ninth clock ended");

	property p_mismatch_standby;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		byte_done && (state_reg == ST_SELECT) && !ce_match && !line_reset |=> (state_reg == ST_STANDBY) && !ack_pend_reg;
	endproperty
	a_mismatch_standby: assert property (p_mismatch_standby) else $error("mismatched select not ignored");

	property p_addr_ack;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		byte_done && (state_reg == ST_ADDR_HI) && !line_reset |=> (state_reg == ST_ADDR_LO) && ack_pend_reg;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("high address byte not acked");

	property p_id_addr;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		addr_valid_out && xfer_out.is_id |-> (xfer_out.byte_addr[BYTE_ADDR_W-1:ID_ADDR_W] == '0);
	endproperty
	a_id_addr: assert property (p_id_addr) else $error("id page address wider than five bits");

	property p_wp_nack;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		byte_done && (state_reg == ST_DATA) && wp_high |=> !ack_pend_reg && !data_valid_out;
	endproperty
	a_wp_nack: assert property (p_wp_nack) else $error("data acked while write protected");

endmodule // eas_slave
`default_nettype wire

//--- common/eas_pkg.sv
`default_nettype none
package eas_pkg;

	// --------------------------------------------------
	// select byte layout
	// --------------------------------------------------
	localparam int         SEL_TYPE_LSB = 4;
	localparam int         SEL_TYPE_W   = 4;
	localparam int         SEL_CE_LSB   = 1;
	localparam int         SEL_CE_W     = 3;
	localparam int         SEL_RW_BIT   = 0;
	localparam logic [3:0] TYPE_MAIN    = 4'hA;
	localparam logic [3:0] TYPE_IDPAGE  = 4'hB;

	// --------------------------------------------------
	// address byte layout
	// --------------------------------------------------
	localparam int BYTE_W       = 8;
	localparam int BYTE_ADDR_W  = 12;
	localparam int MAIN_HI_W    = 4;
	localparam int ID_ADDR_W    = 5;
	localparam int ID_LOCK_BIT  = 2;

	// --------------------------------------------------
	// bit counter values within one byte slot
	// --------------------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [3:0] BIT_STOP  = 4'h1;

	// --------------------------------------------------
	// types
	// --------------------------------------------------
	typedef enum {
		ST_IDLE,
		ST_SELECT,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_DATA,
		ST_READ,
		ST_STANDBY
	} eas_state_t;

	typedef struct packed {
		logic                   is_id;
		logic                   rd;
		logic                   lock_cmd;
		logic [BYTE_ADDR_W-1:0] byte_addr;
	} eas_xfer_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic ce2;
		logic ce1;
		logic ce0;
		logic wp;
	} eas_pins_t;

endpackage
`default_nettype wire

//--- core/eas_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eas_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// --------------------------------------------------
	// two flip-flop synchroniser
	// --------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule // eas_sync
`default_nettype wire

//--- core/eas_shift.sv
`timescale 1ns/10ps
`default_nettype none
module eas_shift (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	input  wire logic       clear_in,
	input  wire logic       sample_in,
	input  wire logic       bit_in,
	output logic      [7:0] byte_out,
	output logic      [3:0] count_out,
	output logic            byte_done_out,
	output logic            ack_clk_out
);
	import eas_pkg::*;

	logic [7:0] byte_reg;
	logic [3:0] cnt_reg;
	logic       done_reg;
	logic       ack_reg;
	wire        at_ack = (cnt_reg == BIT_ACK);

	// --------------------------------------------------
	// msb-first shifter with ninth clock slot
	// --------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			byte_reg <= 8'h00;
			cnt_reg  <= BIT_FIRST;
			done_reg <= 1'b0;
			ack_reg  <= 1'b0;
		end else begin
			done_reg <= sample_in && !clear_in && (cnt_reg == BIT_LAST);
			ack_reg  <= sample_in && !clear_in && at_ack;
			if (clear_in) begin
				cnt_reg <= BIT_FIRST;
			end else if (sample_in && at_ack) begin
				cnt_reg <= BIT_FIRST;
			end else if (sample_in) begin
				byte_reg <= {byte_reg[6:0], bit_in};
				cnt_reg  <= cnt_reg + 4'h1;
			end
		end
	end

	assign byte_out      = byte_reg;
	assign count_out     = cnt_reg;
	assign byte_done_out = done_reg;
	assign ack_clk_out   = ack_reg;

endmodule // eas_shift
`default_nettype wire

//--- testbench/eas_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
module eas_i2c_master (
	input  wire logic clk_sys_in,
	input  wire logic sda_oe_in,
	output logic      scl_out,
	output logic      sda_out
);
	// ----------------------------------------
	// open-drain wire with pull-up
	// ----------------------------------------
	logic scl_r = 1'b1;
	logic sda_r = 1'b1;
	assign scl_out = scl_r;
	assign sda_out = sda_r & ~sda_oe_in;

	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	// ----------------------------------------
	// bus conditions and bytes
	// ----------------------------------------
	task automatic start();
		wt(2);
		sda_r = 1'b1;
		wt(2);
		scl_r = 1'b1;
		wt(4);
		sda_r = 1'b0;
		wt(4);
		scl_r = 1'b0;
	endtask

	task automatic stop();
		wt(2);
		sda_r = 1'b0;
		wt(2);
		scl_r = 1'b1;
		wt(4);
		sda_r = 1'b1;
		wt(4);
	endtask

	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			wt(2);
			sda_r = b[i];
			wt(2);
			scl_r = 1'b1;
			wt(4);
			scl_r = 1'b0;
		end
		wt(2);
		sda_r = 1'b1;
		wt(2);
		scl_r = 1'b1;
		wt(3);
		ack = ~sda_out;
		wt(1);
		scl_r = 1'b0;
		wt(4);
	endtask
endmodule // eas_i2c_master
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import eas_pkg::*;
	logic       clk_sys_in = 1'b0;
	logic       rst_b_in   = 1'b0;
	logic [2:0] ce         = 3'h0;
	logic       wp         = 1'b0;
	logic       busy       = 1'b0;
	wire        scl;
	wire        sda;
	logic       sda_oe;
	logic       sdo;
	eas_xfer_t  xo;
	eas_xfer_t  cap_x;
	logic       av, dv, ws;
	logic [7:0] dout, hi, lo, d;
	logic [3:0] t;
	logic [2:0] c;
	logic       id, ok;
	int errors = 0, n_tests = 0, n_av = 0, n_dv = 0, n_ws = 0, cyc = 0;
	int seed = 32'h2f028444;
	int i, k, j, nd, av0, dv0, ws0;

	always #5 clk_sys_in = ~clk_sys_in;

	eas_i2c_master m (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe & ~sdo), .scl_out(scl), .sda_out(sda));

	eas_slave dut (
		.clk_sys_in            (clk_sys_in),
		.rst_b_in              (rst_b_in),
		.scl_in                (scl),
		.sda_in                (sda),
		.sda_out               (sdo),
		.sda_oe_out            (sda_oe),
		.chip_enable_strap_2_in(ce[2]),
		.chip_enable_strap_1_in(ce[1]),
		.chip_enable_strap_0_in(ce[0]),
		.write_protect_input_in(wp),
		.write_busy_in         (busy),
		.xfer_out              (xo),
		.addr_valid_out        (av),
		.data_out              (dout),
		.data_valid_out        (dv),
		.write_start_out       (ws)
	);

	// ----------------------------------------
	// pulse monitor and timeout
	// ----------------------------------------
	always @(negedge clk_sys_in) begin
		cyc++;
		if (av === 1'b1) begin
			n_av++;
			cap_x <= xo;
		end
		if (dv === 1'b1) n_dv++;
		if (ws === 1'b1) n_ws++;
		if (cyc > 60000) begin
			errors++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic sendx(input logic [7:0] b, input logic e);
		logic a;
		m.send(b, a);
		chk(a, e);
	endtask

	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk_sys_in);
		rst_b_in = 1'b1;
		repeat (6) @(negedge clk_sys_in);
		for (i = 0; i < 32; i++) begin
			t  = 4'(i >> 1);
			ce = 3'($random(seed));
			c  = i[0] ? ce : ~ce;
			ok = (t == TYPE_MAIN || t == TYPE_IDPAGE) && i[0];
			m.start();
			sendx({t, c, 1'b0}, ok);
			sendx(8'h00, ok);
			m.stop();
		end
		for (k = 0; k < 16; k++) begin
			id = 1'($random(seed));
			hi = 8'($random(seed));
			lo = 8'($random(seed));
			d  = 8'($random(seed));
			wp = 1'($random(seed));
			nd = 1 + k % 2;
			av0 = n_av;
			dv0 = n_dv;
			ws0 = n_ws;
			m.start();
			sendx({3'b101, id, ce, 1'b0}, 1'b1);
			sendx(hi, 1'b1);
			sendx(lo, 1'b1);
			for (j = 0; j < nd; j++) sendx(8'(d + j), ~wp);
			m.stop();
			m.wt(8);
			chk(n_av - av0, 1);
			chk(cap_x.is_id, id);
			chk(cap_x.byte_addr, id ? {7'h00, lo[4:0]} : {hi[3:0], lo});
			chk(cap_x.lock_cmd, id & hi[2]);
			chk(cap_x.rd, 1'b0);
			chk(n_dv - dv0, wp ? 0 : nd);
			chk(n_ws - ws0, wp ? 0 : 1);
			if (!wp) chk(dout, 8'(d + nd - 1));
		end
		wp  = 1'b0;
		av0 = n_av;
		ws0 = n_ws;
		m.start();
		sendx({TYPE_MAIN, ce, 1'b0}, 1'b1);
		sendx(8'h12, 1'b1);
		sendx(8'h34, 1'b1);
		m.start();
		sendx({TYPE_MAIN, ce, 1'b1}, 1'b1);
		m.stop();
		m.wt(8);
		chk(n_av - av0, 1);
		chk(cap_x.byte_addr, 12'h234);
		chk(xo.rd, 1'b1);
		chk(n_ws - ws0, 0);
		m.start();
		sendx({TYPE_IDPAGE, ce, 1'b0}, 1'b1);
		m.stop();
		m.wt(8);
		chk(n_ws - ws0, 0);
		busy = 1'b1;
		m.start();
		sendx({TYPE_MAIN, ce, 1'b0}, 1'b0);
		m.stop();
		busy = 1'b0;
		m.wt(4);
		m.start();
		sendx({TYPE_MAIN, ce, 1'b0}, 1'b1);
		m.stop();
		m.wt(8);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
